// ===== logic/pcs_counter.sv
/*
  Free-running statistics counter with a software load port.
  Assumes load and increment are synchronous one-cycle strobes on clk.
*/
`timescale 1ns/10ps
`default_nettype none

module pcs_counter
  import pcs_pkg::*;
#(
  parameter int unsigned W = PCS_DATA_W
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         inc,
  output var  logic [W-1:0] count_ff
);

  // The reset value is one bus word, so wider counters cannot be served.
  if ((W < 1) || (W > PCS_DATA_W))
  begin : g_bad_width
    $error("pcs_counter: width must lie between one and the bus width");
  end

  // A software load wins over an event counted in the same cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_ff <= PCS_CNT_RST[W-1:0];
    else if (load)
      count_ff <= load_val;
    else if (inc)
      count_ff <= count_ff + {{(W-1){1'b0}}, 1'b1}; // Rolls to zero.
  end

endmodule : pcs_counter

`default_nettype wire

// ===== logic/pcs_line_mem.sv
/*
  Small memory holding word two of each cache line; registered read data.
  Assumes the caller arbitrates between fill and software writes.
*/
`timescale 1ns/10ps
`default_nettype none

module pcs_line_mem
  import pcs_pkg::*;
#(
  parameter int unsigned DEPTH = PCS_LINES,
  parameter int unsigned W     = PCS_DATA_W,
  parameter int unsigned AW    = PCS_IDX_W
)
(
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [W-1:0]  wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic [W-1:0]  rdata_ff
);

  logic [W-1:0] mem [DEPTH];

  if ((W < 1) || (DEPTH != (1 << AW)))
  begin : g_bad_shape
    $error("pcs_line_mem: depth must equal two to the address width");
  end

  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  always_ff @(posedge clk)
  begin
    rdata_ff <= mem[raddr];
  end

endmodule : pcs_line_mem

`default_nettype wire

// ===== logic/pcs_pkg.sv
/*
  Shared constants for the prefetch cache statistics and line access block:
  register offsets, widths, reset values, bus encodings and bus states.
  Assumes a single 32-bit AHB-Lite slave port on one clock.
*/
`default_nettype none

package pcs_pkg;

  localparam int unsigned PCS_DATA_W  = 32;
  localparam int unsigned PCS_IDX_W   = 4;
  localparam int unsigned PCS_LINES   = 16;
  localparam int unsigned PCS_DEC_W   = 12;

  // Register byte offsets within the slave's window.
  localparam logic [11:0] PCS_OFS_ACCESS = 12'h000;
  localparam logic [11:0] PCS_OFS_WORD2  = 12'h004;
  localparam logic [11:0] PCS_OFS_HIT    = 12'h008;
  localparam logic [11:0] PCS_OFS_MISS   = 12'h00C;

  // Field position of the line index inside the access register.
  localparam int unsigned PCS_IDX_LSB = 0;

  // Reset values and the counter maximum.
  localparam logic [31:0] PCS_CNT_RST  = 32'h0000_0000;
  localparam logic [3:0]  PCS_IDX_RST  = 4'h0;
  localparam logic [31:0] PCS_ZERO_W   = 32'h0000_0000;
  localparam logic [31:0] PCS_CNT_MAX  = 32'hFFFF_FFFF;

  // Bus encodings.
  localparam logic       PCS_HRESP_OKAY = 1'b0;

  typedef enum logic [0:0] {
    PCS_ST_IDLE,
    PCS_ST_BUSY
  } pcs_state_t;

endpackage : pcs_pkg

`default_nettype wire

// ===== logic/pcs_top.sv
/*
  Software view of the prefetch cache: line index, word two of the chosen
  line, and hit and miss statistics counters, behind an AHB-Lite slave.
  Assumes the cache lookup logic gives one access report per cycle on
  the same clock, and that the code protection level comes from a pin.
*/
`timescale 1ns/10ps
`default_nettype none

module pcs_top
  import pcs_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output var  logic [31:0]           hrdata,
  output var  logic                  hreadyout,
  output var  logic                  hresp,
  input  wire logic                  code_protect_pin,
  input  wire logic                  acc_valid,
  input  wire logic                  acc_fetch,
  input  wire logic                  acc_load,
  input  wire logic                  acc_cacheable,
  input  wire logic                  acc_hit,
  input  wire logic                  fill_we,
  input  wire logic [PCS_IDX_W-1:0]  fill_index,
  input  wire logic [PCS_DATA_W-1:0] fill_data
);

  pcs_state_t             state_ff;
  pcs_state_t             nxt_state;
  logic [PCS_DEC_W-1:0]   addr_ff;
  logic                   write_ff;
  logic [31:0]            hrdata_ff;
  logic                   hreadyout_ff;
  logic                   hresp_ff;
  logic                   prot_meta_ff;
  logic                   prot_ff;
  logic [PCS_IDX_W-1:0]   idx_ff;
  logic [31:0]            word_rdata;
  logic [31:0]            hit_cnt;
  logic [31:0]            miss_cnt;
  logic                   accept;
  logic                   busy;
  logic                   bus_we;
  logic                   sel_access;
  logic                   sel_word;
  logic                   sel_hit;
  logic                   sel_miss;
  logic                   hit_ev;
  logic                   miss_ev;
  logic                   hit_load;
  logic                   miss_load;
  logic                   mem_we;
  logic [PCS_IDX_W-1:0]   mem_waddr;
  logic [31:0]            mem_wdata;
  logic [31:0]            nxt_rdata;

  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;

  // The protection level is not timed to hclk, so it is synchronised.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prot_meta_ff <= 1'b1;
      prot_ff      <= 1'b1;
    end
    else
    begin
      prot_meta_ff <= code_protect_pin;
      prot_ff      <= prot_meta_ff;
    end
  end

  // Every transfer takes one wait state, which leaves time for the
  // registered read of the line memory.
  assign accept = hsel && htrans[1] && hready && (state_ff == PCS_ST_IDLE);
  assign busy   = (state_ff == PCS_ST_BUSY);
  assign bus_we = busy && write_ff;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      PCS_ST_IDLE:
      begin
        if (accept)
          nxt_state = PCS_ST_BUSY;
      end
      PCS_ST_BUSY:
        nxt_state = PCS_ST_IDLE;
      default:
        nxt_state = PCS_ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_ff <= PCS_ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_ff  <= '0;
      write_ff <= 1'b0;
    end
    else if (accept)
    begin
      addr_ff  <= haddr[PCS_DEC_W-1:0];
      write_ff <= hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout_ff <= 1'b1;
      hresp_ff     <= PCS_HRESP_OKAY;
    end
    else
    begin
      hreadyout_ff <= (nxt_state == PCS_ST_IDLE);
      hresp_ff     <= PCS_HRESP_OKAY;
    end
  end

  assign sel_access = (addr_ff == PCS_OFS_ACCESS);
  assign sel_word   = (addr_ff == PCS_OFS_WORD2);
  assign sel_hit    = (addr_ff == PCS_OFS_HIT);
  assign sel_miss   = (addr_ff == PCS_OFS_MISS);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      idx_ff <= PCS_IDX_RST;
    else if (bus_we && sel_access)
      idx_ff <= hwdata[PCS_IDX_LSB +: PCS_IDX_W];
  end

  // A line fill outranks a software write to the word in the same cycle.
  always_comb
  begin
    mem_we    = fill_we || (bus_we && sel_word);
    mem_waddr = fill_we ? fill_index : idx_ff;
    mem_wdata = fill_we ? fill_data : hwdata;
  end

  pcs_line_mem #(
    .DEPTH (PCS_LINES),
    .W     (PCS_DATA_W),
    .AW    (PCS_IDX_W)
  ) u_line_mem (
    .clk      (hclk),
    .we       (mem_we),
    .waddr    (mem_waddr),
    .wdata    (mem_wdata),
    .raddr    (idx_ff),
    .rdata_ff (word_rdata)
  );

  assign hit_ev  = acc_valid && acc_cacheable && acc_hit
                   && (acc_fetch || acc_load);
  assign miss_ev = acc_valid && acc_cacheable && !acc_hit
                   && acc_fetch;
  assign hit_load  = bus_we && sel_hit;
  assign miss_load = bus_we && sel_miss;

  pcs_counter #(
    .W (PCS_DATA_W)
  ) u_hit_cnt (
    .clk      (hclk),
    .rst_n    (hresetn),
    .load     (hit_load),
    .load_val (hwdata),
    .inc      (hit_ev),
    .count_ff (hit_cnt)
  );

  pcs_counter #(
    .W (PCS_DATA_W)
  ) u_miss_cnt (
    .clk      (hclk),
    .rst_n    (hresetn),
    .load     (miss_load),
    .load_val (hwdata),
    .inc      (miss_ev),
    .count_ff (miss_cnt)
  );

  // Unmapped offsets read as zero so nothing leaks from other state.
  always_comb
  begin
    nxt_rdata = PCS_ZERO_W;
    if (sel_access)
      nxt_rdata[PCS_IDX_LSB +: PCS_IDX_W] = idx_ff;
    else if (sel_word)
      nxt_rdata = prot_ff ? PCS_ZERO_W : word_rdata;
    else if (sel_hit)
      nxt_rdata = hit_cnt;
    else if (sel_miss)
      nxt_rdata = miss_cnt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_ff <= PCS_ZERO_W;
    else if (busy && !write_ff)
      hrdata_ff <= nxt_rdata;
  end

  sequence s_word_read;
    busy && !write_ff && sel_word;
  endsequence

  sequence s_transfer;
    accept ##1 !hreadyout ##1 hreadyout;
  endsequence

  property p_word_open;
    @(posedge hclk) disable iff (!hresetn)
    (s_word_read and !prot_ff) |=> (hrdata == $past(word_rdata));
  endproperty
  a_word_open: assert property (p_word_open)
    else $error("word two read did not return the line word");

  property p_word_hidden;
    @(posedge hclk) disable iff (!hresetn)
    (s_word_read and prot_ff) |=> (hrdata == PCS_ZERO_W);
  endproperty
  a_word_hidden: assert property (p_word_hidden)
    else $error("protected line word was revealed");

  property p_hit_write;
    @(posedge hclk) disable iff (!hresetn)
    hit_load |=> (hit_cnt == $past(hwdata));
  endproperty
  a_hit_write: assert property (p_hit_write)
    else $error("hit counter write was not stored");

  property p_hit_inc;
    @(posedge hclk) disable iff (!hresetn)
    (hit_ev && !hit_load) |=> (hit_cnt == $past(hit_cnt) + 32'h0000_0001);
  endproperty
  a_hit_inc: assert property (p_hit_inc)
    else $error("hit counter did not advance on a hit");

  property p_hit_hold;
    @(posedge hclk) disable iff (!hresetn)
    (!(acc_valid && acc_cacheable) && !hit_load) |=> $stable(hit_cnt);
  endproperty
  a_hit_hold: assert property (p_hit_hold)
    else $error("hit counter moved on a non-cacheable access");

  property p_miss_write;
    @(posedge hclk) disable iff (!hresetn)
    miss_load |=> (miss_cnt == $past(hwdata));
  endproperty
  a_miss_write: assert property (p_miss_write)
    else $error("miss counter write was not stored");

  property p_miss_inc;
    @(posedge hclk) disable iff (!hresetn)
    (acc_valid && acc_cacheable && acc_fetch && !acc_hit && !miss_load)
      |=> (miss_cnt == $past(miss_cnt) + 32'h0000_0001);
  endproperty
  a_miss_inc: assert property (p_miss_inc)
    else $error("miss counter did not advance on a fetch miss");

  property p_miss_hold;
    @(posedge hclk) disable iff (!hresetn)
    (!(acc_valid && acc_cacheable) && !miss_load) |=> $stable(miss_cnt);
  endproperty
  a_miss_hold: assert property (p_miss_hold)
    else $error("miss counter moved on a non-cacheable access");

  property p_wrap;
    @(posedge hclk) disable iff (!hresetn)
    (hit_ev && !hit_load && hit_cnt == PCS_CNT_MAX)
      |=> (hit_cnt == PCS_CNT_RST);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("hit counter did not wrap to zero");

  property p_one_wait;
    @(posedge hclk) disable iff (!hresetn)
    accept |-> s_transfer;
  endproperty
  a_one_wait: assert property (p_one_wait)
    else $error("transfer did not complete after one wait state");

endmodule : pcs_top

`default_nettype wire

// ===== verif/pcs_core_model.sv
/*
  Core-side model: access reports and line fills, driven on command.
  Assumes the bench calls its tasks; all changes follow a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none

module pcs_core_model
(
  input  wire logic        clk,
  output var  logic        acc_valid,
  output var  logic        acc_fetch,
  output var  logic        acc_load,
  output var  logic        acc_cacheable,
  output var  logic        acc_hit,
  output var  logic        fill_we,
  output var  logic [3:0]  fill_index,
  output var  logic [31:0] fill_data
);
  initial
  begin
    acc_valid = 1'b0;
    {acc_fetch, acc_load, acc_cacheable, acc_hit} = 4'h0;
    fill_we = 1'b0;
    fill_index = 4'h0;
    fill_data = 32'h0000_0000;
  end

  // Qualifiers are inverted once the report ends so stale values never help.
  task automatic access(input logic [3:0] k);
    @(posedge clk);
    acc_valid <= 1'b1;
    {acc_fetch, acc_load, acc_cacheable, acc_hit} <= k;
    @(posedge clk);
    acc_valid <= 1'b0;
    {acc_fetch, acc_load, acc_cacheable, acc_hit} <= ~k;
  endtask : access

  task automatic fill(input logic [3:0] i, input logic [31:0] d);
    @(posedge clk);
    fill_we <= 1'b1;
    fill_index <= i;
    fill_data <= d;
    @(posedge clk);
    fill_we <= 1'b0;
    fill_index <= ~i;
    fill_data <= ~d;
  endtask : fill
endmodule : pcs_core_model

`default_nettype wire

// ===== verif/tb_pcs_top.sv
/*
  Self-checking bench for pcs_top with an AHB-Lite master and core model.
  Assumes one slave, so hready is fed back from hreadyout.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_pcs_top;
  import pcs_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic        prot = 1'b1;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        av, af, al, ac, ah, fw;
  logic [3:0]  fi;
  logic [31:0] fd;
  int          err_total = 0;
  int          samples_checked = 0;

  always #2.5 hclk = ~hclk;

  pcs_core_model i_core (.clk(hclk), .acc_valid(av), .acc_fetch(af),
    .acc_load(al), .acc_cacheable(ac), .acc_hit(ah), .fill_we(fw),
    .fill_index(fi), .fill_data(fd));

  pcs_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .code_protect_pin(prot),
    .acc_valid(av), .acc_fetch(af), .acc_load(al), .acc_cacheable(ac),
    .acc_hit(ah), .fill_we(fw), .fill_index(fi), .fill_data(fd));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // The master waits on hready as long as needed; only the watchdog ends it.
  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0_0000, a};
    hwrite <= w;
    hsize <= 3'b010;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, {31'h0, PCS_HRESP_OKAY});
    hsel <= 1'b0;
  endtask : ahb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0000_0000, x);
    chk(x, e);
  endtask : rc

  task automatic t_regs;
    wr(PCS_OFS_HIT, 32'h1234_5678);
    wr(PCS_OFS_MISS, 32'hA5A5_5A5A);
    rc(PCS_OFS_HIT, 32'h1234_5678);
    rc(PCS_OFS_MISS, 32'hA5A5_5A5A);
    rc(12'h010, 32'h0000_0000);
  endtask : t_regs

  // Order of the code: {fetch, load, cacheable, hit}.
  task automatic t_count;
    wr(PCS_OFS_HIT, 32'h0000_0000);
    wr(PCS_OFS_MISS, 32'h0000_0000);
    i_core.access(4'b1011);
    i_core.access(4'b0111);
    rc(PCS_OFS_HIT, 32'h0000_0002);
    i_core.access(4'b1001);
    i_core.access(4'b1000);
    i_core.access(4'b0100);
    rc(PCS_OFS_HIT, 32'h0000_0002);
    rc(PCS_OFS_MISS, 32'h0000_0000);
    i_core.access(4'b1010);
    i_core.access(4'b0110);
    rc(PCS_OFS_MISS, 32'h0000_0001);
    rc(PCS_OFS_HIT, 32'h0000_0002);
  endtask : t_count

  task automatic t_wrap;
    wr(PCS_OFS_HIT, PCS_CNT_MAX);
    wr(PCS_OFS_MISS, PCS_CNT_MAX);
    i_core.access(4'b1011);
    i_core.access(4'b1010);
    rc(PCS_OFS_HIT, 32'h0000_0000);
    rc(PCS_OFS_MISS, 32'h0000_0000);
  endtask : t_wrap

  task automatic t_word;
    i_core.fill(4'h5, 32'hCAFE_0005);
    i_core.fill(4'hF, 32'h0BAD_000F);
    wr(PCS_OFS_ACCESS, 32'h0000_0005);
    rc(PCS_OFS_ACCESS, 32'h0000_0005);
    rc(PCS_OFS_WORD2, 32'hCAFE_0005);
    wr(PCS_OFS_ACCESS, 32'h0000_000F);
    rc(PCS_OFS_WORD2, 32'h0BAD_000F);
    wr(PCS_OFS_WORD2, 32'h1357_9BDF);
    rc(PCS_OFS_WORD2, 32'h1357_9BDF);
    @(posedge hclk);
    prot <= 1'b1;
    repeat (4) @(posedge hclk);
    rc(PCS_OFS_WORD2, 32'h0000_0000);
  endtask : t_word

  task automatic end_sim;
    $display("err_total=%0d samples_checked=%0d", err_total,
             samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    prot <= 1'b0;
    repeat (4) @(posedge hclk);
    t_regs();
    t_count();
    t_wrap();
    t_word();
    end_sim();
  end

  // Whole run needs well under a thousand cycles.
  initial
  begin
    #25000;
    err_total++;
    end_sim();
  end
endmodule : tb_pcs_top

`default_nettype wire
